// [rtl/lsc_defines.svh]
// Constants for the serial segment panel controller: offsets, field positions, reset values
// and timing figures.
// Assumes it is included by bare name from every file that needs it.
`ifndef LSC_DEFINES_SVH
`define LSC_DEFINES_SVH

// ==========================================================================
// Clocks
`define LSC_CLK_HZ 50000000
`define LSC_OSC_HZ 32768

// ==========================================================================
// Bus register byte offsets
`define LSC_OFS_STATUS 4'h0
`define LSC_OFS_CTRL 4'h4

// ==========================================================================
// Control register fields and reset value
`define LSC_CTRL_LINK_EN 0
`define LSC_CTRL_WD_CLEAR 1
`define LSC_CTRL_RESET 1'b1

// ==========================================================================
// Status register fields
`define LSC_ST_OSC 0
`define LSC_ST_BIAS_ON 1
`define LSC_ST_BIAS_THIRD 2
`define LSC_ST_COM_LO 3
`define LSC_ST_COM_HI 4
`define LSC_ST_TONE_ON 5
`define LSC_ST_TONE_HIGH 6
`define LSC_ST_TB_EN 7
`define LSC_ST_WD_EN 8
`define LSC_ST_FLAG_EN 9
`define LSC_ST_FSEL_LO 10
`define LSC_ST_FSEL_HI 12
`define LSC_ST_WD_FLAG 13
`define LSC_ST_TEST 14

// ==========================================================================
// Serial framing
`define LSC_ID_BITS 4'd3
`define LSC_ADDR_BITS 4'd6
`define LSC_NIB_BITS 4'd4
`define LSC_CMD_BITS 4'd9

// ==========================================================================
// Power-on values of the configuration, and the time base bit selected at fsel 0
`define LSC_FSEL_RESET 3'h7
`define LSC_COM_RESET 2'h2
`define LSC_FSEL_MAX 4'he

`endif

// [rtl/lsc_pkg.sv]
// Types shared by the serial segment panel controller files.
// Assumes nothing of its surroundings.
package lsc_pkg;

  // Serial interface states, Gray coded along ID, address, data.
  typedef enum logic [2:0] {
    LSC_ST_ID = 3'h0,
    LSC_ST_ADDR = 3'h1,
    LSC_ST_DATA = 3'h3,
    LSC_ST_CMD = 3'h2,
    LSC_ST_IDLE = 3'h6
  } lsc_state_t;

  // Transaction kinds selected by the mode identifier.
  typedef enum logic [2:0] {
    LSC_MODE_READ = 3'h6,
    LSC_MODE_WRITE = 3'h5,
    LSC_MODE_CMD = 3'h4
  } lsc_mode_t;

  // Configuration held by command mode.
  typedef struct packed {
    logic test_mode;
    logic flag_en;
    logic wd_en;
    logic tb_en;
    logic [2:0] fsel;
    logic tone_high;
    logic tone_on;
    logic [1:0] com_sel;
    logic bias_third;
    logic bias_on;
    logic osc_on;
  } lsc_cfg_t;

  // Serial pins after synchronisation.
  typedef struct packed {
    logic cs_n;
    logic wr_n;
    logic rd_n;
    logic data;
  } lsc_pins_t;

endpackage : lsc_pkg

// [rtl/lsc_sync.sv]
// Two flip-flop synchroniser for a group of asynchronous inputs.
// Assumes the inputs are static for several clocks around each change.
`timescale 1ns/1ps
`default_nettype none

module lsc_sync #(
  parameter int WIDTH = 4,
  parameter logic [WIDTH-1:0] INIT = '1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Data
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta;

  // =========================================================================
  // Synchroniser
  // The first stage feeds only the second stage.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= INIT;
      q_o <= INIT;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end

endmodule : lsc_sync
`default_nettype wire

// [rtl/lsc_ram.sv]
// Display memory of nibbles with one write port, one read port and a flat view of all bits.
// Assumes writes arrive as single-cycle strobes from the serial logic.
`timescale 1ns/1ps
`default_nettype none

module lsc_ram #(
  parameter int DEPTH = 32,
  parameter int WIDTH = 4,
  parameter int AW = 5
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Write port
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [WIDTH-1:0] wdata_i,
  // Read port
  input wire logic [AW-1:0] raddr_i,
  output logic [WIDTH-1:0] rdata_o,
  // Whole contents
  output logic [DEPTH*WIDTH-1:0] flat_o
);

  logic [WIDTH-1:0] mem [DEPTH];

  // =========================================================================
  // Storage, cleared at reset so the panel starts blank.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
    end else if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  // Read port and flat view of every stored bit.
  always_comb begin
    rdata_o = mem[raddr_i];
    for (int i = 0; i < DEPTH; i++) begin
      flat_o[i*WIDTH +: WIDTH] = mem[i];
    end
  end

endmodule : lsc_ram
`default_nettype wire

// [rtl/lsc_ctrl.sv]
// Serial segment panel controller: serial link, display memory, time base, watchdog,
// tone outputs and a Wishbone register port.
// Assumes the serial pins are asynchronous to clk_i and much slower than it.
`timescale 1ns/1ps
`default_nettype none
`include "lsc_defines.svh"

module lsc_ctrl
  import lsc_pkg::*;
#(
  parameter int unsigned CLK_HZ = `LSC_CLK_HZ,
  parameter int unsigned OSC_HZ = `LSC_OSC_HZ,
  parameter int RAM_DEPTH = 32,
  parameter int RAM_WIDTH = 4
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Serial link pins
  input wire logic cs_n_i,
  input wire logic wr_n_i,
  input wire logic rd_n_i,
  input wire logic data_i,
  output logic data_o,
  output logic data_oe_o,
  // Panel outputs
  output logic [RAM_DEPTH*RAM_WIDTH-1:0] segment_drive_o,
  output logic bias_on_o,
  output logic bias_third_o,
  output logic [1:0] com_sel_o,
  output logic panel_clk_o,
  // Tone and flag outputs
  output logic tone_out_o,
  output logic tone_out_n_o,
  output logic flag_n_o
);

  // Returns the watchdog limit in 128 Hz ticks: four periods of the time base.
  function automatic logic [9:0] lsc_wd_limit(input logic [2:0] fsel);
    lsc_wd_limit = 10'h200 >> fsel;
  endfunction : lsc_wd_limit

  lsc_pins_t pins;
  logic wr_prev;
  logic rd_prev;
  logic link_en;
  logic link_act;
  logic wr_rise;
  logic rd_fall;
  lsc_state_t state;
  lsc_mode_t mode;
  logic [3:0] bit_cnt;
  logic [7:0] shift;
  logic [5:0] addr;
  logic [2:0] wbuf;
  logic [1:0] rbit;
  logic ram_we;
  logic [5:0] ram_waddr;
  logic [3:0] ram_wdata;
  logic [3:0] ram_rdata;
  logic [RAM_DEPTH*RAM_WIDTH-1:0] ram_flat;
  logic cmd_stb;
  logic [7:0] cmd_code;
  lsc_cfg_t cfg;
  logic [26:0] osc_acc;
  logic [26:0] next_osc_acc;
  logic osc_tick;
  logic [14:0] tb_cnt;
  logic tick128;
  logic tb_level;
  logic [9:0] wd_cnt;
  logic wd_hit;
  logic wd_flag;
  logic wd_clear;
  logic bus_wd_clear;
  logic tone_level;
  logic [31:0] status_word;

  // =========================================================================
  // Pin synchronisers
  lsc_sync #(
    .WIDTH(4),
    .INIT(4'he)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({cs_n_i, wr_n_i, rd_n_i, data_i}),
    .q_o(pins)
  );

  // Strobe history for edge detection.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_prev <= 1'b1;
      rd_prev <= 1'b1;
    end else begin
      wr_prev <= pins.wr_n;
      rd_prev <= pins.rd_n;
    end
  end

  // Link is active only while selected and enabled by software.
  assign link_act = ~pins.cs_n & link_en;
  assign wr_rise = pins.wr_n & ~wr_prev;
  assign rd_fall = ~pins.rd_n & rd_prev;

  // =========================================================================
  // Serial interface state machine
  // Deselect returns everything to identifier reception; the host then starts anew.
  always_ff @(posedge clk_i) begin
    ram_we <= 1'b0;
    cmd_stb <= 1'b0;
    if (rst_i || !link_act) begin
      state <= LSC_ST_ID;
      mode <= LSC_MODE_CMD;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      addr <= 6'h00;
      wbuf <= 3'h0;
      rbit <= 2'h0;
      ram_waddr <= 6'h00;
      ram_wdata <= 4'h0;
      cmd_code <= 8'h00;
    end else if (wr_rise) begin
      bit_cnt <= bit_cnt + 4'h1;
      case (state)
        LSC_ST_ID: begin
          shift <= {shift[6:0], pins.data};
          if (bit_cnt == `LSC_ID_BITS - 4'h1) begin
            bit_cnt <= 4'h0;
            case ({shift[1:0], pins.data})
              LSC_MODE_READ: begin
                mode <= LSC_MODE_READ;
                state <= LSC_ST_ADDR;
              end
              LSC_MODE_WRITE: begin
                mode <= LSC_MODE_WRITE;
                state <= LSC_ST_ADDR;
              end
              LSC_MODE_CMD: begin
                mode <= LSC_MODE_CMD;
                state <= LSC_ST_CMD;
              end
              default: state <= LSC_ST_IDLE;
            endcase
          end
        end
        LSC_ST_ADDR: begin
          addr <= {addr[4:0], pins.data};
          if (bit_cnt == `LSC_ADDR_BITS - 4'h1) begin
            bit_cnt <= 4'h0;
            rbit <= 2'h0;
            state <= LSC_ST_DATA;
          end
        end
        LSC_ST_DATA: begin
          if (mode == LSC_MODE_WRITE) begin
            if (bit_cnt == `LSC_NIB_BITS - 4'h1) begin
              ram_we <= 1'b1;
              ram_waddr <= addr;
              ram_wdata <= {pins.data, wbuf};
              addr <= addr + 6'h01;
              bit_cnt <= 4'h0;
              rbit <= 2'h0;
            end else begin
              wbuf[bit_cnt[1:0]] <= pins.data;
            end
          end else begin
            bit_cnt <= bit_cnt;
          end
        end
        LSC_ST_CMD: begin
          shift <= {shift[6:0], pins.data};
          if (bit_cnt == `LSC_CMD_BITS - 4'h1) begin
            cmd_stb <= 1'b1;
            cmd_code <= shift;
            bit_cnt <= 4'h0;
          end
        end
        default: bit_cnt <= bit_cnt;
      endcase
    end else if (rd_fall && state == LSC_ST_DATA) begin
      rbit <= rbit + 2'h1;
      if (mode == LSC_MODE_READ && rbit == 2'h3) begin
        addr <= addr + 6'h01;
      end
    end
  end

  // Read data leaves on the falling read strobe; the host samples it after the rise.
  // The line is released once the synchronised write strobe is low, so in a
  // read-then-write access both sides drive the data line for up to three clocks after the strobe fall.
  always_ff @(posedge clk_i) begin
    if (rst_i || !link_act || state != LSC_ST_DATA) begin
      data_o <= 1'b0;
      data_oe_o <= 1'b0;
    end else if (rd_fall) begin
      data_o <= ram_rdata[rbit];
      data_oe_o <= 1'b1;
    end else if (!pins.wr_n) begin
      data_oe_o <= 1'b0;
    end
  end

  // =========================================================================
  // Display memory
  lsc_ram #(
    .DEPTH(RAM_DEPTH),
    .WIDTH(RAM_WIDTH),
    .AW(5)
  ) u_ram (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .we_i(ram_we),
    .waddr_i(ram_waddr[4:0]),
    .wdata_i(ram_wdata),
    .raddr_i(addr[4:0]),
    .rdata_o(ram_rdata),
    .flat_o(ram_flat)
  );

  // =========================================================================
  // Command decoder
  // Each command touches only its own field, except 8'h00, which clears both osc_on and bias_on, 8'b0010_????, which sets bias_third
  // and, unless bits 3:2 are 2'h3, com_sel, and a flag_en clear or a watchdog clear (8'h0e, 8'h0f), which also clear wd_flag.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg <= '0;
      cfg.fsel <= `LSC_FSEL_RESET;
      cfg.com_sel <= `LSC_COM_RESET;
    end else if (cmd_stb) begin
      casez (cmd_code)
        8'b0000_0000: begin
          cfg.osc_on <= 1'b0;
          cfg.bias_on <= 1'b0;
        end
        8'b0000_0001: cfg.osc_on <= 1'b1;
        8'b0000_0010: cfg.bias_on <= 1'b0;
        8'b0000_0011: cfg.bias_on <= 1'b1;
        8'b0000_0100: cfg.tb_en <= 1'b0;
        8'b0000_0110: cfg.tb_en <= 1'b1;
        8'b0000_0101: cfg.wd_en <= 1'b0;
        8'b0000_0111: cfg.wd_en <= 1'b1;
        8'b0000_1000: cfg.tone_on <= 1'b0;
        8'b0000_1001: cfg.tone_on <= 1'b1;
        8'b0010_????: begin
          cfg.bias_third <= cmd_code[0];
          if (cmd_code[3:2] != 2'h3) begin
            cfg.com_sel <= cmd_code[3:2];
          end
        end
        8'b010?_????: cfg.tone_high <= 1'b1;
        8'b0110_????: cfg.tone_high <= 1'b0;
        8'b100?_????: cfg.flag_en <= cmd_code[3];
        8'b101?_0???: cfg.fsel <= cmd_code[2:0];
        8'b1110_0000: cfg.test_mode <= 1'b1;
        8'b1110_0011: cfg.test_mode <= 1'b0;
        default: cfg.test_mode <= cfg.test_mode;
      endcase
    end
  end

  // =========================================================================
  // Crystal tick from the fast clock by a fractional accumulator.
  assign next_osc_acc = osc_acc + 27'(OSC_HZ);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_acc <= '0;
      osc_tick <= 1'b0;
    end else if (next_osc_acc >= 27'(CLK_HZ)) begin
      osc_acc <= next_osc_acc - 27'(CLK_HZ);
      osc_tick <= cfg.osc_on;
    end else begin
      osc_acc <= next_osc_acc;
      osc_tick <= 1'b0;
    end
  end

  // Shared /256 prefix in the low bits, time base stages above it.
  assign tick128 = osc_tick && tb_cnt[7:0] == 8'hff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tb_cnt <= '0;
    end else if (cmd_stb && cmd_code == 8'b0000_1101) begin
      tb_cnt <= {7'h00, tb_cnt[7:0]};
    end else if (osc_tick) begin
      tb_cnt <= tb_cnt + 15'h0001;
    end
  end

  assign tb_level = tb_cnt[4'(`LSC_FSEL_MAX - {1'b0, cfg.fsel})];

  // =========================================================================
  // Watchdog counting 128 Hz ticks up to four time base periods.
  assign wd_hit = tick128 && (wd_cnt + 10'h001 >= lsc_wd_limit(cfg.fsel));
  assign wd_clear = (cmd_stb && cmd_code[7:1] == 7'b0000_111) || bus_wd_clear;

  always_ff @(posedge clk_i) begin
    if (rst_i || wd_clear) begin
      wd_cnt <= '0;
    end else if (wd_hit) begin
      wd_cnt <= '0;
    end else if (tick128) begin
      wd_cnt <= wd_cnt + 10'h001;
    end
  end

  // Timeout flag sticks; a new timeout wins over a clear in the same cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wd_flag <= 1'b0;
    end else if (wd_hit) begin
      wd_flag <= 1'b1;
    end else if (wd_clear || (cmd_stb && cmd_code[7:5] == 3'b100 && !cmd_code[3])) begin
      wd_flag <= 1'b0;
    end
  end

  // =========================================================================
  // Output pins: flag, tone pair and panel.
  assign tone_level = cfg.tone_high ? tb_cnt[2] : tb_cnt[3];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_n_o <= 1'b1;
      tone_out_o <= 1'b0;
      tone_out_n_o <= 1'b0;
      panel_clk_o <= 1'b0;
      segment_drive_o <= '0;
    end else begin
      flag_n_o <= ~(cfg.flag_en & ((cfg.tb_en & tb_level) | (cfg.wd_en & wd_flag)));
      tone_out_o <= cfg.tone_on & tone_level;
      tone_out_n_o <= cfg.tone_on & ~tone_level;
      panel_clk_o <= tb_cnt[6];
      segment_drive_o <= cfg.bias_on ? ram_flat : '0;
    end
  end

  assign bias_on_o = cfg.bias_on;
  assign bias_third_o = cfg.bias_third;
  assign com_sel_o = cfg.com_sel;

  // =========================================================================
  // Wishbone slave: status view and control register.
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`LSC_ST_OSC] = cfg.osc_on;
    status_word[`LSC_ST_BIAS_ON] = cfg.bias_on;
    status_word[`LSC_ST_BIAS_THIRD] = cfg.bias_third;
    status_word[`LSC_ST_COM_HI:`LSC_ST_COM_LO] = cfg.com_sel;
    status_word[`LSC_ST_TONE_ON] = cfg.tone_on;
    status_word[`LSC_ST_TONE_HIGH] = cfg.tone_high;
    status_word[`LSC_ST_TB_EN] = cfg.tb_en;
    status_word[`LSC_ST_WD_EN] = cfg.wd_en;
    status_word[`LSC_ST_FLAG_EN] = cfg.flag_en;
    status_word[`LSC_ST_FSEL_HI:`LSC_ST_FSEL_LO] = cfg.fsel;
    status_word[`LSC_ST_WD_FLAG] = wd_flag;
    status_word[`LSC_ST_TEST] = cfg.test_mode;
  end

  // Answer one cycle after the request; unmapped addresses read zero.
  always_ff @(posedge clk_i) begin
    bus_wd_clear <= 1'b0;
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      link_en <= `LSC_CTRL_RESET;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
        wb_dat_o <= 32'h0000_0000;
        if (wb_adr_i == `LSC_OFS_STATUS && !wb_we_i) begin
          wb_dat_o <= status_word;
        end else if (wb_adr_i == `LSC_OFS_CTRL && !wb_we_i) begin
          wb_dat_o <= {31'h0000_0000, link_en};
        end else if (wb_adr_i == `LSC_OFS_CTRL && wb_sel_i[0]) begin
          link_en <= wb_dat_i[`LSC_CTRL_LINK_EN];
          bus_wd_clear <= wb_dat_i[`LSC_CTRL_WD_CLEAR];
        end
      end
    end
  end

endmodule : lsc_ctrl
`default_nettype wire

// [testbench/lsc_ctrl_props.sv]
// Checker of the serial panel controller, watching the top module's ports.
// Assumes it is bound onto every lsc_ctrl instance.
`timescale 1ns/1ps
`default_nettype none
// ====
// Checker
module lsc_ctrl_props #(
  parameter int RAM_DEPTH = 32,
  parameter int RAM_WIDTH = 4
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // Link
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic data_o,
  input wire logic data_oe_o,
  // Panel, tone and flag
  input wire logic [RAM_DEPTH*RAM_WIDTH-1:0] segment_drive_o,
  input wire logic bias_on_o,
  input wire logic bias_third_o,
  input wire logic [1:0] com_sel_o,
  input wire logic tone_out_o,
  input wire logic tone_out_n_o,
  input wire logic flag_n_o
);
  // All checks run on the one clock and pause in reset.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered in one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  reset_values_a: assert property ($fell(rst_i) |-> flag_n_o && !tone_out_o && !bias_on_o
    && !bias_third_o && com_sel_o == 2'h2 && !data_oe_o) else $error("bad reset values");
  tone_pair_a: assert property (!(tone_out_o && tone_out_n_o))
    else $error("both tone outputs high");
  seg_blank_a: assert property (!bias_on_o && !$past(bias_on_o) |-> segment_drive_o == '0)
    else $error("segments driven with bias off");
  com_legal_a: assert property (com_sel_o != 2'h3)
    else $error("illegal common count");
  oe_release_a: assert property (cs_n_i [*5] |-> !data_oe_o)
    else $error("data line driven while deselected");
  read_hold_a: assert property ((rd_n_i && !cs_n_i) [*8] |-> $stable(data_o))
    else $error("read data changed without strobe");
endmodule : lsc_ctrl_props
bind lsc_ctrl lsc_ctrl_props #(.RAM_DEPTH(RAM_DEPTH), .RAM_WIDTH(RAM_WIDTH)) u_props (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .cs_n_i, .rd_n_i, .data_o, .data_oe_o,
  .segment_drive_o, .bias_on_o, .bias_third_o, .com_sel_o, .tone_out_o, .tone_out_n_o,
  .flag_n_o);
`default_nettype wire

// [testbench/lsc_host.sv]
// Host model of the serial link: select, strobes and data.
// Assumes the bench resolves the data wire and returns it on data_w_i.
`timescale 1ns/1ps
`default_nettype none
// ====
// Host model
module lsc_host (
  // Clock and wire level
  input wire logic clk_i,
  input wire logic data_w_i,
  // Pins driven by the host
  output logic cs_n_o,
  output logic wr_n_o,
  output logic rd_n_o,
  output logic hd_o,
  output logic hoe_o
);
  // Idle pins at time zero.
  initial begin
    cs_n_o = 1'b1;
    wr_n_o = 1'b1;
    rd_n_o = 1'b1;
    hd_o = 1'b1;
    hoe_o = 1'b0;
  end
  task wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask : wt
  // A high pulse resets the link before each new identifier.
  task sel();
    cs_n_o <= 1'b1;
    wt(8);
    cs_n_o <= 1'b0;
    wt(4);
  endtask : sel
  task fin();
    cs_n_o <= 1'b1;
    hoe_o <= 1'b0;
    wt(8);
  endtask : fin
  // Data is set with the strobe fall and held well past its rise.
  task wbit(input logic b);
    hoe_o <= 1'b1;
    hd_o <= b;
    wr_n_o <= 1'b0;
    wt(8);
    wr_n_o <= 1'b1;
    wt(8);
  endtask : wbit
  task send(input logic [15:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) wbit(v[i]);
  endtask : send
  task wnib(input logic [3:0] d);
    for (int i = 0; i < 4; i++) wbit(d[i]);
  endtask : wnib
  // Bits are sampled between the strobe rise and the next fall.
  task rnib(output logic [3:0] d);
    for (int i = 0; i < 4; i++) begin
      hoe_o <= 1'b0;
      rd_n_o <= 1'b0;
      wt(8);
      rd_n_o <= 1'b1;
      wt(2);
      d[i] = data_w_i;
      wt(6);
    end
  endtask : rnib
endmodule : lsc_host
`default_nettype wire

// [testbench/lsc_ctrl_test.sv]
// Self-checking bench of the serial panel controller.
// Assumes lsc_ctrl, its checker and the host model are compiled first.
`timescale 1ns/1ps
`default_nettype none
// ====
// Bench
module lsc_ctrl_test;
  localparam int CLK = 50000000;
  localparam int OSC = 5000000;
  logic clk_i, rst_i;
  logic wb_cyc_i, wb_stb_i, wb_we_i;
  logic [3:0] wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic wb_ack_o, data_o, data_oe_o, bias_on_o, bias_third_o, panel_clk_o;
  logic tone_out_o, tone_out_n_o, flag_n_o, cs_n, wr_n, rd_n, hd, hoe;
  logic [1:0] com_sel_o;
  logic [127:0] segment_drive;
  logic [3:0] nb;
  logic [7:0] cl [8] = '{8'h01, 8'h03, 8'h25, 8'h09, 8'h40, 8'ha0, 8'h06, 8'h88};
  int n_errors = 0, compares = 0, n;
  longint t0;
  // The line has a pull-up, so nobody driving reads high.
  wire logic data_w;
  assign data_w = hoe ? hd : (data_oe_o ? data_o : 1'b1);
  always #10 clk_i = ~clk_i;
  lsc_ctrl #(.CLK_HZ(CLK), .OSC_HZ(OSC)) dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .cs_n_i(cs_n), .wr_n_i(wr_n),
    .rd_n_i(rd_n), .data_i(data_w), .data_o, .data_oe_o, .segment_drive_o(segment_drive), .bias_on_o,
    .bias_third_o, .com_sel_o, .panel_clk_o, .tone_out_o, .tone_out_n_o, .flag_n_o);
  lsc_host host (.clk_i, .data_w_i(data_w), .cs_n_o(cs_n), .wr_n_o(wr_n), .rd_n_o(rd_n),
    .hd_o(hd), .hoe_o(hoe));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One classic bus cycle; read data is kept in q, taken at the edge that sees ack.
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    chk(wb_ack_o, 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task cmd(input logic [7:0] c);
    host.sel();
    host.send(16'h4, 3);
    host.send({7'h0, c, 1'b0}, 9);
    host.fin();
  endtask : cmd
  task flag_wait();
    n = 0;
    while (flag_n_o !== 1'b0 && n < 30000) begin
      @(posedge clk_i);
      n++;
    end
    chk(n > 7000 && n <= 10240, 1'b1);
  endtask : flag_wait
  task test_done();
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done
  task t_reset();
    wb(0, 4'h0, 0);
    chk(q, 32'h1c10);
    wb(0, 4'h4, 0);
    chk(q, 32'h1);
    wb(1, 4'h0, 32'hffff);
    wb(0, 4'h8, 0);
    chk(q, 32'h0);
    wb(0, 4'h0, 0);
    chk(q, 32'h1c10);
    $display("reset test done");
  endtask : t_reset
  task t_cmd();
    host.sel();
    host.send(16'h4, 3);
    foreach (cl[i]) host.send({7'h0, cl[i], 1'b0}, 9);
    host.fin();
    wb(0, 4'h0, 0);
    chk(q, 32'h2ef);
    chk({bias_on_o, bias_third_o, com_sel_o}, 4'hd);
    cmd(8'h60);
    wb(0, 4'h0, 0);
    chk(q[6], 1'b0);
    cmd(8'h02);
    chk(bias_on_o, 1'b0);
    wb(1, 4'h4, 0, 4'he);
    wb(0, 4'h4, 0);
    chk(q, 32'h1);
    wb(1, 4'h4, 0);
    cmd(8'h03);
    chk(bias_on_o, 1'b0);
    wb(1, 4'h4, 1);
    cmd(8'h03);
    chk(bias_on_o, 1'b1);
    $display("command test done");
  endtask : t_cmd
  task t_mem();
    host.sel();
    host.send(16'h5, 3);
    host.send(16'd30, 6);
    host.wnib(4'ha);
    host.wnib(4'h5);
    host.wnib(4'hc);
    host.fin();
    chk({segment_drive[127:120], segment_drive[3:0]}, 12'h5ac);
    host.sel();
    host.send(16'h6, 3);
    host.send(16'd30, 6);
    host.rnib(nb);
    chk(nb, 4'ha);
    chk(data_oe_o, 1'b1);
    host.rnib(nb);
    chk(nb, 4'h5);
    host.rnib(nb);
    chk(nb, 4'hc);
    host.fin();
    chk(data_oe_o, 1'b0);
    $display("memory test done");
  endtask : t_mem
  task t_rmw();
    host.sel();
    host.send(16'h5, 3);
    host.send(16'd30, 6);
    host.rnib(nb);
    chk(nb, 4'ha);
    host.wnib(4'h3);
    host.rnib(nb);
    chk(nb, 4'h5);
    host.wnib(4'h6);
    host.fin();
    chk(segment_drive[127:120], 8'h63);
    $display("read then write test done");
  endtask : t_rmw
  task t_abort();
    host.sel();
    host.send(16'h5, 3);
    host.send(16'd0, 6);
    host.wbit(1'b1);
    host.wbit(1'b1);
    host.fin();
    host.sel();
    host.send(16'h5, 3);
    host.send(16'd1, 6);
    host.wnib(4'h7);
    host.fin();
    chk(segment_drive[7:0], 8'h7c);
    $display("abort test done");
  endtask : t_abort
  task t_clk();
    @(posedge panel_clk_o);
    t0 = $time;
    @(posedge panel_clk_o);
    chk(32'($time - t0), 128 * 20 * (CLK / OSC));
    @(posedge tone_out_o);
    t0 = $time;
    @(posedge tone_out_o);
    chk(32'($time - t0), 16 * 20 * (CLK / OSC));
    @(posedge clk_i);
    chk(tone_out_n_o, !tone_out_o);
    $display("clock test done");
  endtask : t_clk
  task t_wdt();
    cmd(8'h04);
    cmd(8'ha7);
    cmd(8'h0e);
    cmd(8'h07);
    flag_wait();
    host.wt(3000);
    chk(flag_n_o, 1'b0);
    wb(0, 4'h0, 0);
    chk(q[13:7], 7'h7e);
    cmd(8'h0e);
    chk(flag_n_o, 1'b1);
    flag_wait();
    cmd(8'h80);
    chk(flag_n_o, 1'b1);
    wb(0, 4'h0, 0);
    chk(q[9:7], 3'h2);
    $display("watchdog test done");
  endtask : t_wdt
  // Test mode on and oscillator off, then a reset in mid-run restores the defaults.
  task t_rst();
    cmd(8'he0);
    cmd(8'h00);
    chk(bias_on_o, 1'b0);
    wb(0, 4'h0, 0);
    chk(q, 32'h5d2c);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(0, 4'h0, 0);
    chk(q, 32'h1c10);
    $display("second reset test done");
  endtask : t_rst
  // Main sequence.
  initial begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 4'h0;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0000_0000;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_cmd();
    t_mem();
    t_rmw();
    t_abort();
    t_clk();
    t_wdt();
    t_rst();
    test_done();
  end
  // Cuts a hang short.
  initial begin
    repeat (100000) @(posedge clk_i);
    n_errors++;
    test_done();
  end
endmodule : lsc_ctrl_test
`default_nettype wire
